// ---- include/area_decode_pkg.sv ----
package area_decode_pkg;

    // Register indices; the byte address on the APB is four times the index.
    localparam logic [7:0] IDX_AREA0_BASE    = 8'hc8;
    localparam logic [7:0] IDX_AREA0_MASK    = 8'hc9;
    localparam logic [7:0] IDX_AREA1_BASE    = 8'hca;
    localparam logic [7:0] IDX_AREA1_MASK    = 8'hcb;
    localparam logic [7:0] IDX_AREA2_BASE    = 8'hcc;
    localparam logic [7:0] IDX_AREA2_MASK    = 8'hcd;
    localparam logic [7:0] IDX_AREA3_BASE    = 8'hce;
    localparam logic [7:0] IDX_AREA3_MASK    = 8'hcf;
    localparam logic [7:0] IDX_AREA0_CTRL    = 8'hd0;
    localparam logic [7:0] IDX_OUTSIDE_CTRL  = 8'hd4;
    localparam logic [7:0] IDX_PORT4_FUNC    = 8'hd5;
    localparam logic [7:0] IDX_STATUS        = 8'hd6;

    // Reset values.
    localparam logic [7:0] BASE_RESET        = 8'hff;
    localparam logic [7:0] MASK_RESET        = 8'hff;
    localparam logic [7:0] CTRL_RESET        = 8'h00;
    localparam logic [7:0] CTRL2_RESET       = 8'h80;
    localparam logic [3:0] PORT4_FUNC_RESET  = 4'h0;

    // Bus control field positions.
    localparam int CTRL_ENABLE_BIT  = 7;
    localparam int CTRL_BUS8_BIT    = 3;
    localparam int CTRL_WAIT_LSB    = 0;
    localparam int CTRL_WAIT_W      = 3;

    // Base register covers address bits 23..16.
    localparam int BASE_LSB         = 16;
    localparam int NUM_AREAS        = 4;
    localparam int AREA_W           = 3;
    localparam logic [2:0] AREA_NONE = 3'h4;

    // Settings that a bus cycle runs with.
    typedef struct packed {
        logic                   bus8;
        logic [CTRL_WAIT_W-1:0] waits;
    } cycle_set_s;

endpackage

// ---- rtl/chip_select_area_decoder.sv ----
// The APB slave port is this design's own decision.
`timescale 1ns/100ps

// Operation
// - Four areas plus one outside setting.
// - Width and waits set per area independently.
// - Matching address asserts that area's select.
// - Select reaches pin only in function mode.
// - Area defined by base and mask only.
// - Every bus cycle compared against all areas.
// - Matching area's control settings drive cycle.
// - Base register holds address bits 23..16.
// - Lower sixteen start bits are zero.
// - Mask bit one removes address bit.
// - Mask coverage differs between areas.
// - Lowest numbered matching area wins.
// - Control bit 7 enables; area two enabled.
// - Area zero mask spans bits 20..8.
// - Areas two, three mask 22..15; reset ones.
module chip_select_area_decoder
    import area_decode_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Processor bus cycle.
    input  wire logic        bus_cycle,
    input  wire logic [23:0] bus_addr,
    input  wire logic        bus_wait_n,
    output logic             cycle_ready,
    output cycle_set_s       cycle_set,
    // Port 4 pins 0..3.
    input  wire logic [3:0]  port4_latch,
    output logic      [3:0]  area_select_n
);

    // Register file state.
    logic [7:0] base_r [NUM_AREAS];
    logic [7:0] base_nxt [NUM_AREAS];
    logic [7:0] mask_r [NUM_AREAS];
    logic [7:0] mask_nxt [NUM_AREAS];
    logic [7:0] ctrl_r [NUM_AREAS+1];
    logic [7:0] ctrl_nxt [NUM_AREAS+1];
    logic [3:0] fc_r;
    logic [3:0] fc_nxt;

    // Bus cycle state.
    logic                   active_r;
    logic [3:0]             sel_r;
    logic [3:0]             sel_nxt;
    logic [AREA_W-1:0]      area_r;
    logic [AREA_W-1:0]      area_nxt;
    cycle_set_s             set_r;
    cycle_set_s             set_nxt;
    logic [CTRL_WAIT_W-1:0] cnt_r;
    logic [CTRL_WAIT_W-1:0] cnt_nxt;

    logic [9:0]        widx;
    logic [31:0]       rd_word;
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              acc;
    logic              hit;
    logic [3:0]        match;
    logic [AREA_W-1:0] win;
    logic              start;
    cycle_set_s        win_set;

    // Ignore mask per area; coverage differs so area sizes differ.
    function automatic logic [23:0] ignore_bits(input int unsigned k, input logic [7:0] m);
        logic [23:0] ig;
        ig = 24'h00_0000;
        unique case (k)
            0: begin
                ig[7:0]   = 8'hff;                    // Below 256 bytes never compared.
                ig[8]     = m[0];
                ig[14:9]  = {6{m[1]}};                // One bit spans six address bits.
                ig[20:15] = m[7:2];
            end
            1: begin
                ig[7:0]   = 8'hff;
                ig[8]     = m[0];
                ig[15:9]  = {7{m[1]}};
                ig[21:16] = m[7:2];
            end
            default: begin
                ig[14:0]  = 15'h7fff;                 // Smallest size is 32 Kbytes.
                ig[22:15] = m;
            end
        endcase
        return ig;
    endfunction

    // Address comparison for all four areas on every cycle.
    for (genvar k = 0; k < NUM_AREAS; k++) begin : g_cmp
        logic [23:0] start_addr;
        logic [23:0] ign;
        assign start_addr = {base_r[k], {BASE_LSB{1'b0}}};
        assign ign        = ignore_bits(k, mask_r[k]);
        assign match[k]   = ctrl_r[k][CTRL_ENABLE_BIT]
                            && (((bus_addr ^ start_addr) & ~ign) == 24'h00_0000);
    end

    // Lowest numbered area wins; otherwise the outside settings apply.
    always_comb begin
        win = AREA_NONE;
        for (int k = NUM_AREAS - 1; k >= 0; k--) begin
            if (match[k]) begin
                win = AREA_W'(k);
            end
        end
        win_set.bus8  = ctrl_r[win][CTRL_BUS8_BIT];
        win_set.waits = ctrl_r[win][CTRL_WAIT_LSB +: CTRL_WAIT_W];
    end

    // Register index, APB access phase and the first edge of a processor bus cycle.
    assign widx  = paddr[11:2];
    assign acc   = psel && penable;
    assign start = bus_cycle && !active_r;

    // Register writes; APB writes complete in a single access cycle.
    always_comb begin
        base_nxt = base_r;
        mask_nxt = mask_r;
        ctrl_nxt = ctrl_r;
        fc_nxt   = fc_r;
        if (acc && pwrite) begin
            for (int k = 0; k < NUM_AREAS; k++) begin
                if (widx == {2'b00, IDX_AREA0_BASE} + 10'(2 * k)) begin
                    base_nxt[k] = pwdata[7:0];
                end
                if (widx == {2'b00, IDX_AREA0_MASK} + 10'(2 * k)) begin
                    mask_nxt[k] = pwdata[7:0];
                end
            end
            for (int k = 0; k <= NUM_AREAS; k++) begin
                if (widx == {2'b00, IDX_AREA0_CTRL} + 10'(k)) begin
                    ctrl_nxt[k] = pwdata[7:0];
                end
            end
            if (widx == {2'b00, IDX_PORT4_FUNC}) begin
                fc_nxt = pwdata[3:0];
            end
        end
    end

    // Registers the configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NUM_AREAS; k++) begin
                base_r[k] <= BASE_RESET;
                mask_r[k] <= MASK_RESET;
                ctrl_r[k] <= (k == 2) ? CTRL2_RESET : CTRL_RESET;
            end
            ctrl_r[NUM_AREAS] <= CTRL_RESET;
            fc_r <= PORT4_FUNC_RESET;
        end else begin
            base_r <= base_nxt;
            mask_r <= mask_nxt;
            ctrl_r <= ctrl_nxt;
            fc_r   <= fc_nxt;
        end
    end

    // Read decode; unmapped addresses read zero and are refused.
    always_comb begin
        hit     = 1'b0;
        rd_word = 32'h0000_0000;
        for (int k = 0; k < NUM_AREAS; k++) begin
            if (widx == {2'b00, IDX_AREA0_BASE} + 10'(2 * k)) begin
                hit     = 1'b1;
                rd_word = {24'h00_0000, base_r[k]};
            end
            if (widx == {2'b00, IDX_AREA0_MASK} + 10'(2 * k)) begin
                hit     = 1'b1;
                rd_word = {24'h00_0000, mask_r[k]};
            end
        end
        for (int k = 0; k <= NUM_AREAS; k++) begin
            if (widx == {2'b00, IDX_AREA0_CTRL} + 10'(k)) begin
                hit     = 1'b1;
                rd_word = {24'h00_0000, ctrl_r[k]};
            end
        end
        if (widx == {2'b00, IDX_PORT4_FUNC}) begin
            hit     = 1'b1;
            rd_word = {28'h000_0000, fc_r};
        end
        if (widx == {2'b00, IDX_STATUS}) begin
            hit     = 1'b1;
            rd_word = {24'h00_0000, active_r, cycle_ready, 3'h0, area_r};
        end
        if (!hit) begin
            rd_word = 32'h0000_0000;
        end
    end

    // Read data is taken in the setup cycle and stands through the access cycle,
    // so the bus sees a flip-flop; a status read is therefore a snapshot of setup.
    always_comb begin
        prdata_nxt = prdata_r;
        if (psel && !penable) begin
            prdata_nxt = rd_word;
        end
    end

    // Registers the read data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // Every access completes in its first access cycle; an unmapped index is refused.
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata  = prdata_r;

    // Bus cycle tracking: selection and settings are latched at the cycle start
    // so that a mid-cycle register write cannot glitch a chip select.
    always_comb begin
        sel_nxt  = sel_r;
        area_nxt = area_r;
        set_nxt  = set_r;
        cnt_nxt  = cnt_r;
        if (start) begin
            sel_nxt  = 4'h0;
            if (win != AREA_NONE) begin
                sel_nxt[win[1:0]] = 1'b1;
            end
            area_nxt = win;
            set_nxt  = win_set;
            cnt_nxt  = win_set.waits;
        end else if (!bus_cycle) begin
            sel_nxt  = 4'h0;
            area_nxt = AREA_NONE;
        end else if (cnt_r != '0) begin
            cnt_nxt  = cnt_r - CTRL_WAIT_W'(1);
        end
    end

    // Registers the bus cycle state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= 1'b0;
            sel_r    <= 4'h0;
            area_r   <= AREA_NONE;
            set_r    <= '0;
            cnt_r    <= '0;
        end else begin
            active_r <= bus_cycle;
            sel_r    <= sel_nxt;
            area_r   <= area_nxt;
            set_r    <= set_nxt;
            cnt_r    <= cnt_nxt;
        end
    end

    // Ready once the inserted waits are spent and the device no longer stretches.
    assign cycle_ready = active_r && bus_cycle && (cnt_r == '0) && bus_wait_n;
    assign cycle_set   = set_r;

    // Pin mux: a pin not switched to its select function keeps its port value.
    for (genvar k = 0; k < NUM_AREAS; k++) begin : g_pin
        assign area_select_n[k] = fc_r[k] ? ~sel_r[k] : port4_latch[k];
    end

    // Checks on the decode, the bus cycle and the register bus.
    a_select_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(sel_r)) else $error("more than one area selected");

    a_select_winner: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> (area_r == $past(win)) && (sel_r[0] == ($past(win) == 3'h0)))
        else $error("selected area differs from match winner");

    a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        start && !ctrl_r[0][CTRL_ENABLE_BIT] |=> !sel_r[0])
        else $error("disabled area zero was selected");

    a_settings_used: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> set_r == $past(win_set)) else $error("cycle settings not from winner");

    a_select_held: assert property (@(posedge pclk) disable iff (!presetn)
        active_r && bus_cycle && !start |=> $stable(sel_r))
        else $error("select changed within a bus cycle");

    a_select_drops: assert property (@(posedge pclk) disable iff (!presetn)
        !bus_cycle |=> sel_r == 4'h0) else $error("select held without bus cycle");

    a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !fc_r[1] |-> area_select_n[1] == port4_latch[1]) else $error("select leaked to port pin");

    a_wait_count: assert property (@(posedge pclk) disable iff (!presetn)
        start && win_set.waits == 3'h2 |=> !cycle_ready ##1 !cycle_ready)
        else $error("ready before waits were spent");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !hit |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");

endmodule

// ---- tb/mem_model.sv ----
`timescale 1ns/100ps

// External memory that stretches every selected cycle by a programmable count.
module mem_model (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Pin side.
    input  wire logic [3:0] area_select_n,
    input  wire logic [3:0] stall,
    output logic            bus_wait_n
);
    logic [3:0] held_r;
    logic [3:0] held_nxt;

    // Count cycles spent selected; an idle cycle restarts the count, so cycles never share a stall.
    always_comb begin
        held_nxt = (&area_select_n) ? 4'h0 : held_r + ((held_r < stall) ? 4'h1 : 4'h0);
    end

    // Registers the count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_r <= 4'h0;
        end else begin
            held_r <= held_nxt;
        end
    end

    // Wait request stays low until the stall count has run out.
    assign bus_wait_n = (&area_select_n) | (held_r >= stall);
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps

module tb_top
    import area_decode_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bus_cycle;
    logic [23:0] bus_addr;
    logic        bus_wait_n;
    logic        cycle_ready;
    cycle_set_s  cycle_set;
    logic [3:0]  port4_latch;
    logic [3:0]  area_select_n;
    logic [3:0]  stall;
    logic [31:0] rd;
    logic        err;
    int          mismatches;
    int          total_checks;

    chip_select_area_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_cycle(bus_cycle), .bus_addr(bus_addr), .bus_wait_n(bus_wait_n),
        .cycle_ready(cycle_ready), .cycle_set(cycle_set), .port4_latch(port4_latch),
        .area_select_n(area_select_n));

    mem_model partner (.pclk(pclk), .presetn(presetn), .area_select_n(area_select_n), .stall(stall),
        .bus_wait_n(bus_wait_n));

    // Free-running 200 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a register and compares the word.
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask

    // One processor bus cycle: start, check settings, count waits, end.
    task automatic cyc(input logic [23:0] a, input logic [3:0] sel, input logic [3:0] set, input int lat);
        int n;
        @(posedge pclk);
        bus_cycle <= 1'b1;
        bus_addr  <= a;
        @(posedge pclk);
        #1;
        check(area_select_n, sel);
        check(cycle_set, set);
        n = 0;
        while (cycle_ready !== 1'b1 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (cycle_ready !== 1'b1) begin
            mismatches++;
            complete_run();
        end
        check(n, lat);
        check(area_select_n, sel);
        @(posedge pclk);
        bus_cycle <= 1'b0;
        @(posedge pclk);
        #1;
        check(area_select_n, 4'hf);
    endtask

    // Main sequence.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        bus_cycle = 1'b0;
        bus_addr = 24'h00_0000;
        port4_latch = 4'ha;
        stall = 4'h0;
        mismatches = 0;
        total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rchk(IDX_AREA0_BASE + 8'(i), 32'h0000_00ff);
        end
        rchk(IDX_AREA0_CTRL, 32'h0000_0000);
        rchk(IDX_AREA0_CTRL + 8'h02, 32'h0000_0080);
        apb(1'b0, 8'h10, 8'h00);
        check(err, 1'b1);
        check(area_select_n, 4'ha);
        apb(1'b1, IDX_PORT4_FUNC, 8'h0f);
        cyc(24'h80_0000, 4'b1011, 4'h0, 0);
        cyc(24'h7f_ffff, 4'hf, 4'h0, 0);
        apb(1'b1, IDX_AREA0_BASE, 8'h01);
        apb(1'b1, IDX_AREA0_MASK, 8'h07);
        apb(1'b1, IDX_AREA0_CTRL, 8'h8b);
        apb(1'b1, IDX_OUTSIDE_CTRL, 8'h0d);
        rchk(IDX_AREA0_BASE, 32'h0000_0001);
        cyc(24'h01_ffff, 4'b1110, 4'hb, 3);
        cyc(24'h02_0000, 4'hf, 4'hd, 5);
        cyc(24'h00_ffff, 4'hf, 4'hd, 5);
        apb(1'b1, IDX_AREA1_BASE, 8'h01);
        apb(1'b1, IDX_AREA0_CTRL + 8'h01, 8'h81);
        cyc(24'h01_0000, 4'b1110, 4'hb, 3);
        cyc(24'h3f_0000, 4'b1101, 4'h1, 1);
        apb(1'b1, IDX_AREA0_CTRL, 8'h0b);
        cyc(24'h01_0000, 4'b1101, 4'h1, 1);
        apb(1'b1, IDX_AREA3_BASE, 8'h40);
        apb(1'b1, IDX_AREA3_MASK, 8'h00);
        apb(1'b1, IDX_AREA0_CTRL + 8'h03, 8'h8f);
        cyc(24'h40_7fff, 4'b0111, 4'hf, 7);
        cyc(24'h40_8000, 4'hf, 4'hd, 5);
        apb(1'b1, IDX_OUTSIDE_CTRL, 8'h02);
        cyc(24'h40_8000, 4'hf, 4'h2, 2);
        stall = 4'h9;
        cyc(24'h40_0000, 4'b0111, 4'hf, 9);
        stall = 4'h0;
        rchk(IDX_STATUS, {29'h0000_0000, AREA_NONE});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(IDX_AREA0_BASE, 32'h0000_00ff);
        check(area_select_n, 4'ha);
        complete_run();
    end
endmodule
